// ### include/bpc_chopper_defines.vh
/*
 * Constants for the two-bridge constant off-time chopper: clock rate,
 * switching times, derived cycle counts, state codes and counter widths.
 * Assumes a single 25 MHz system clock; all counts derive from it.
 */
`ifndef BPC_CHOPPER_DEFINES_VH
`define BPC_CHOPPER_DEFINES_VH

// Clock rate
`define BPC_CLK_PERIOD_NS     40
`define BPC_CLK_FREQ_KHZ      25000

// Switching times as printed, in their own units
`define BPC_DEAD_TIME_NS      1000
`define BPC_BLANK_TIME_NS     1000
`define BPC_MIN_ON_TIME_PS    2500000
`define BPC_PUMP_FREQ_KHZ     600

// Dead time: least time, rounded up (25 cycles)
`define BPC_DEAD_CYC   ((`BPC_DEAD_TIME_NS + `BPC_CLK_PERIOD_NS - 1) / `BPC_CLK_PERIOD_NS)
// Blanking: longest time, rounded down (25 cycles)
`define BPC_BLANK_CYC  (`BPC_BLANK_TIME_NS / `BPC_CLK_PERIOD_NS)
// Minimum on-time: least time, rounded up (63 cycles)
`define BPC_MIN_ON_CYC ((`BPC_MIN_ON_TIME_PS + `BPC_CLK_PERIOD_NS * 1000 - 1) / (`BPC_CLK_PERIOD_NS * 1000))
// Pump half period, rounded down (20 cycles)
`define BPC_PUMP_HALF_CYC (`BPC_CLK_FREQ_KHZ / (2 * `BPC_PUMP_FREQ_KHZ))

// Counter widths
`define BPC_TCNT_W     7
`define BPC_OFF_W      16
`define BPC_PUMP_W     5

// Chopper state codes
`define BPC_ST_IDLE     3'h0
`define BPC_ST_DEAD_ON  3'h1
`define BPC_ST_ON       3'h2
`define BPC_ST_OFF_DEAD 3'h3
`define BPC_ST_OFF_REC  3'h4
`define BPC_ST_OFF_END  3'h5

// Gate vector layout {hs1, ls1, hs2, ls2}
`define BPC_G_HS1      3
`define BPC_G_LS1      2
`define BPC_G_HS2      1
`define BPC_G_LS2      0
`define BPC_G_NONE     4'h0

`endif

// ### core/bpc_sync2.v
/*
 * Two-flop synchroniser for a bundle of pin inputs.
 * Assumes inputs are levels that stay stable for several clock periods.
 */
`timescale 1ns/1ps
`default_nettype none

module bpc_sync2 #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         srst_i,
	input  wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);

	reg [W-1:0] stage1;
	reg [W-1:0] stage2;

	// First stage is read only by the second
	always @(posedge clk_i) begin
		if (srst_i) begin
			stage1 <= {W{1'b0}};
			stage2 <= {W{1'b0}};
		end else begin
			stage1 <= d_i;
			stage2 <= stage1;
		end
	end

	assign q_o = stage2;

endmodule // bpc_sync2

`default_nettype wire

// ### core/bpc_chopper_top.v
/*
 * Two independent full-bridge constant off-time current choppers with
 * dead time, blanking, minimum on-time, fast/slow decay with
 * (quasi-)synchronous rectification, enable/protection pull-down and a
 * free-running charge-pump square wave.
 * Assumes: all inputs except the clock and reset come from pins and are
 * asynchronous; the sense inputs are comparator outputs that are high
 * while the sensed current exceeds the reference; an external sequencer
 * supplies phase and per-bridge enable.
 */
// Summary of operation
// - Dead time between legs' transistor switching.
// - Two bridges, independent choppers.
// - Comparator trip starts off-time, bridge off.
// - Stay off full off-time, then on.
// - Turn-on delayed by dead time after off-time.
// - Ignore comparator during blanking after turn-on.
// - Hold bridge on for minimum on-time.
// - Decay low: fast, both conducting transistors off.
// - Decay high: slow, only low side off.
// - Fast decay rectifies with lower transistor only.
// - Slow decay rectifies with upper transistor.
// - Slow decay: other upper on after dead time.
// - Device may pull enable low; driver tolerates.
// - Free-running pump square wave near 600 kHz.
`timescale 1ns/1ps
`default_nettype none
`include "bpc_chopper_defines.vh"

module bpc_chopper_top (
	input  wire        clk_i,
	input  wire        srst_i,
	// Enable pin, shared with protection pull-down
	input  wire        en_i,
	output wire        en_o,
	output wire        en_oe_o,
	input  wire        fault_i,
	// Bridge A controls
	input  wire        phase_a_i,
	input  wire        bridge_en_a_i,
	input  wire        decay_sel_a_i,
	input  wire        sense_trip_a_i,
	input  wire [15:0] offtime_timing_pin_a_i,
	// Bridge B controls
	input  wire        phase_b_i,
	input  wire        bridge_en_b_i,
	input  wire        decay_sel_b_i,
	input  wire        sense_trip_b_i,
	input  wire [15:0] offtime_timing_pin_b_i,
	// Bridge A gate drives
	output wire        gate_hs1_a_o,
	output wire        gate_ls1_a_o,
	output wire        gate_hs2_a_o,
	output wire        gate_ls2_a_o,
	// Bridge B gate drives
	output wire        gate_hs1_b_o,
	output wire        gate_ls1_b_o,
	output wire        gate_hs2_b_o,
	output wire        gate_ls2_b_o,
	// Status and pump
	output wire        chop_off_a_o,
	output wire        chop_off_b_o,
	output wire        pump_oscillator_out_o
);

	localparam NSYNC = 2 + 2 * (4 + `BPC_OFF_W);
	localparam [2:0] ST_IDLE     = `BPC_ST_IDLE;
	localparam [2:0] ST_DEAD_ON  = `BPC_ST_DEAD_ON;
	localparam [2:0] ST_ON       = `BPC_ST_ON;
	localparam [2:0] ST_OFF_DEAD = `BPC_ST_OFF_DEAD;
	localparam [2:0] ST_OFF_REC  = `BPC_ST_OFF_REC;
	localparam [2:0] ST_OFF_END  = `BPC_ST_OFF_END;
	localparam integer DEAD_LAST_I = `BPC_DEAD_CYC - 1;
	localparam integer BLANK_I     = `BPC_BLANK_CYC;
	localparam integer MIN_ON_I    = `BPC_MIN_ON_CYC - 1;
	localparam integer PUMP_LAST_I = `BPC_PUMP_HALF_CYC - 1;
	localparam [`BPC_TCNT_W-1:0] DEAD_LAST  = DEAD_LAST_I[`BPC_TCNT_W-1:0];
	localparam [`BPC_TCNT_W-1:0] BLANK_CYC  = BLANK_I[`BPC_TCNT_W-1:0];
	localparam [`BPC_TCNT_W-1:0] MIN_ON_LST = MIN_ON_I[`BPC_TCNT_W-1:0];
	localparam [`BPC_TCNT_W-1:0] TCNT_MAX   = {`BPC_TCNT_W{1'b1}};
	localparam [`BPC_PUMP_W-1:0] PUMP_LAST  = PUMP_LAST_I[`BPC_PUMP_W-1:0];

	// Gate pattern for a state: conducting diagonal by phase, decay style
	function [3:0] bpc_gates;
		input [2:0] st;
		input       ph;
		input       slow;
		reg   [3:0] on_pat;
		reg   [3:0] hi_keep;
		reg   [3:0] rect_lo;
		reg   [3:0] rect_hi;
		begin
			// Phase high: hs1 with ls2; phase low: hs2 with ls1
			on_pat  = ph ? 4'h9 : 4'h6;
			hi_keep = ph ? 4'h8 : 4'h2;
			rect_lo = ph ? 4'h4 : 4'h1;
			rect_hi = ph ? 4'ha : 4'ha;
			case (st)
				ST_ON:       bpc_gates = on_pat;
				ST_OFF_DEAD: bpc_gates = slow ? hi_keep : `BPC_G_NONE;
				ST_OFF_REC:  bpc_gates = slow ? rect_hi : rect_lo;
				ST_OFF_END:  bpc_gates = slow ? hi_keep : `BPC_G_NONE;
				default:     bpc_gates = `BPC_G_NONE;
			endcase
		end
	endfunction

	// Pin inputs pass two flops before use
	wire [NSYNC-1:0] sync_d;
	wire [NSYNC-1:0] sync_q;
	assign sync_d = {en_i, fault_i,
		phase_a_i, bridge_en_a_i, decay_sel_a_i, sense_trip_a_i, offtime_timing_pin_a_i,
		phase_b_i, bridge_en_b_i, decay_sel_b_i, sense_trip_b_i, offtime_timing_pin_b_i};
	bpc_sync2 #(
		.W (NSYNC)
	) u_sync (
		.clk_i  (clk_i),
		.srst_i (srst_i),
		.d_i    (sync_d),
		.q_o    (sync_q)
	);

	wire                 en_s;
	wire                 fault_s;
	wire [1:0]           phase_s;
	wire [1:0]           ben_s;
	wire [1:0]           decay_s;
	wire [1:0]           trip_s;
	wire [`BPC_OFF_W-1:0] offlen_s [0:1];

	assign en_s        = sync_q[NSYNC-1];
	assign fault_s     = sync_q[NSYNC-2];
	assign phase_s[0]  = sync_q[NSYNC-3];
	assign ben_s[0]    = sync_q[NSYNC-4];
	assign decay_s[0]  = sync_q[NSYNC-5];
	assign trip_s[0]   = sync_q[NSYNC-6];
	assign offlen_s[0] = sync_q[2*`BPC_OFF_W+3:`BPC_OFF_W+4];
	assign phase_s[1]  = sync_q[`BPC_OFF_W+3];
	assign ben_s[1]    = sync_q[`BPC_OFF_W+2];
	assign decay_s[1]  = sync_q[`BPC_OFF_W+1];
	assign trip_s[1]   = sync_q[`BPC_OFF_W];
	assign offlen_s[1] = sync_q[`BPC_OFF_W-1:0];

	// Protection pull-down on the shared enable line
	reg pull_en;
	always @(posedge clk_i) begin
		if (srst_i)
			pull_en <= 1'b0;
		else
			pull_en <= fault_s;
	end

	assign en_o    = 1'b0;                   // Open drain: only ever pulls low
	assign en_oe_o = pull_en;

	// Global run: line high and no fault of our own
	wire run_all;
	assign run_all = en_s & ~fault_s;

	// Gate and status results from both bridges
	wire [3:0] gates [0:1];
	wire [1:0] off_flag;

	// One independent chopper per bridge
	genvar b;
	generate
		for (b = 0; b < 2; b = b + 1) begin : g_bridge
			reg [2:0]             st;
			reg [2:0]             next_st;
			reg [`BPC_TCNT_W-1:0] tcnt;
			reg [`BPC_TCNT_W-1:0] next_tcnt;
			reg [`BPC_OFF_W-1:0]  ocnt;
			reg [`BPC_OFF_W-1:0]  next_ocnt;
			reg                   ph;
			reg                   next_ph;
			reg                   slow;
			reg                   next_slow;
			reg                   trip_pend;
			reg                   next_trip_pend;
			reg [3:0]             gate;
			reg                   off_st;
			wire                  run;
			wire                  trip_seen;
			wire [`BPC_OFF_W-1:0] off_last;
			assign run = run_all & ben_s[b];
			// Comparator ignored during blanking
			assign trip_seen = trip_s[b] & (tcnt >= BLANK_CYC);
			// Zero programmed count still gives one cycle
			assign off_last = (offlen_s[b] == {`BPC_OFF_W{1'b0}}) ?
				{`BPC_OFF_W{1'b0}} : offlen_s[b] - 1'b1;

			// Next-state logic of the chopper
			always @* begin
				next_st        = st;
				next_tcnt      = tcnt;
				next_ocnt      = ocnt;
				next_ph        = ph;
				next_slow      = slow;
				next_trip_pend = trip_pend;
				case (st)
					ST_IDLE: begin
						next_tcnt = {`BPC_TCNT_W{1'b0}};
						next_ph   = phase_s[b];
						if (run)
							next_st = ST_DEAD_ON;
					end
					ST_DEAD_ON: begin
						// All off, then on after dead time
						next_tcnt = tcnt + 1'b1;
						next_ph   = phase_s[b];
						if (tcnt == DEAD_LAST) begin
							next_st        = ST_ON;
							next_tcnt      = {`BPC_TCNT_W{1'b0}};
							next_trip_pend = 1'b0;
						end
					end
					ST_ON: begin
						if (tcnt != TCNT_MAX)
							next_tcnt = tcnt + 1'b1;
						if (trip_seen)
							next_trip_pend = 1'b1;
						if (phase_s[b] != ph) begin
							// Direction change passes through dead time
							next_st   = ST_DEAD_ON;
							next_tcnt = {`BPC_TCNT_W{1'b0}};
						end else if ((trip_pend | trip_seen) && tcnt >= MIN_ON_LST) begin
							next_st        = ST_OFF_DEAD;
							next_tcnt      = {`BPC_TCNT_W{1'b0}};
							next_ocnt      = {`BPC_OFF_W{1'b0}};
							next_slow      = decay_s[b];
							next_trip_pend = 1'b0;
						end
					end
					ST_OFF_DEAD: begin
						next_tcnt = tcnt + 1'b1;
						next_ocnt = ocnt + 1'b1;
						if (ocnt >= off_last) begin
							next_st   = ST_OFF_END;
							next_tcnt = {`BPC_TCNT_W{1'b0}};
						end else if (tcnt == DEAD_LAST)
							next_st = ST_OFF_REC;
					end
					ST_OFF_REC: begin
						next_ocnt = ocnt + 1'b1;
						if (ocnt >= off_last) begin
							next_st   = ST_OFF_END;
							next_tcnt = {`BPC_TCNT_W{1'b0}};
						end
					end
					ST_OFF_END: begin
						// Rectifier off, wait dead time before turn-on
						next_tcnt = tcnt + 1'b1;
						if (tcnt == DEAD_LAST) begin
							next_tcnt      = {`BPC_TCNT_W{1'b0}};
							next_trip_pend = 1'b0;
							if (phase_s[b] != ph)
								next_st = ST_DEAD_ON;
							else
								next_st = ST_ON;
						end
					end
					default: begin
						next_st = ST_IDLE;
					end
				endcase
				// Disable overrides everything and clears timers
				if (!run) begin
					next_st        = ST_IDLE;
					next_tcnt      = {`BPC_TCNT_W{1'b0}};
					next_ocnt      = {`BPC_OFF_W{1'b0}};
					next_trip_pend = 1'b0;
				end
			end

			// State, counters and registered gate drives
			always @(posedge clk_i) begin
				if (srst_i) begin
					st        <= ST_IDLE;
					tcnt      <= {`BPC_TCNT_W{1'b0}};
					ocnt      <= {`BPC_OFF_W{1'b0}};
					ph        <= 1'b0;
					slow      <= 1'b0;
					trip_pend <= 1'b0;
					gate      <= `BPC_G_NONE;
					off_st    <= 1'b0;
				end else begin
					st        <= next_st;
					tcnt      <= next_tcnt;
					ocnt      <= next_ocnt;
					ph        <= next_ph;
					slow      <= next_slow;
					trip_pend <= next_trip_pend;
					gate      <= bpc_gates(next_st, next_ph, next_slow);
					off_st    <= (next_st == ST_OFF_DEAD) || (next_st == ST_OFF_REC) ||
						(next_st == ST_OFF_END);
				end
			end

			assign gates[b]    = gate;
			assign off_flag[b] = off_st;
		end
	endgenerate

	// Gate outputs straight from flops
	assign gate_hs1_a_o = gates[0][`BPC_G_HS1];
	assign gate_ls1_a_o = gates[0][`BPC_G_LS1];
	assign gate_hs2_a_o = gates[0][`BPC_G_HS2];
	assign gate_ls2_a_o = gates[0][`BPC_G_LS2];
	assign gate_hs1_b_o = gates[1][`BPC_G_HS1];
	assign gate_ls1_b_o = gates[1][`BPC_G_LS1];
	assign gate_hs2_b_o = gates[1][`BPC_G_HS2];
	assign gate_ls2_b_o = gates[1][`BPC_G_LS2];
	assign chop_off_a_o = off_flag[0];
	assign chop_off_b_o = off_flag[1];

	// Free-running charge-pump square wave
	reg [`BPC_PUMP_W-1:0] pump_cnt;
	reg                   pump_lvl;
	always @(posedge clk_i) begin
		if (srst_i) begin
			pump_cnt <= {`BPC_PUMP_W{1'b0}};
			pump_lvl <= 1'b0;
		end else if (pump_cnt == PUMP_LAST) begin
			pump_cnt <= {`BPC_PUMP_W{1'b0}};
			pump_lvl <= ~pump_lvl;
		end else begin
			pump_cnt <= pump_cnt + 1'b1;
		end
	end

	assign pump_oscillator_out_o = pump_lvl;

endmodule // bpc_chopper_top

`default_nettype wire

// ### bench/bpc_chopper_monitor.sv
/* Checker on the chopper top ports, bridge A.
   Assumes static off-time and a bench that holds decay steady around off starts. */
`timescale 1ns/1ps
`default_nettype none
module bpc_chopper_monitor (
	input wire logic        clk_i,
	input wire logic        srst_i,
	input wire logic        en_i,
	input wire logic        en_o,
	input wire logic        en_oe_o,
	input wire logic        fault_i,
	input wire logic        phase_a_i,
	input wire logic        bridge_en_a_i,
	input wire logic        decay_sel_a_i,
	input wire logic [15:0] offtime_timing_pin_a_i,
	input wire logic        gate_hs1_a_o,
	input wire logic        gate_ls1_a_o,
	input wire logic        gate_hs2_a_o,
	input wire logic        gate_ls2_a_o,
	input wire logic        chop_off_a_o,
	input wire logic        pump_oscillator_out_o
);
	wire [3:0]   g = {gate_hs1_a_o, gate_ls1_a_o, gate_hs2_a_o, gate_ls2_a_o};
	wire         lsx = gate_ls1_a_o | gate_ls2_a_o;
	logic [15:0] oc;
	logic [4:0]  pc;
	logic        pst;
	// Off-interval length and pump level age
	always @(posedge clk_i) begin
		if (srst_i) begin
			oc <= 16'h0000;
			pc <= 5'h00;
			pst <= 1'b0;
		end else begin
			oc <= chop_off_a_o ? oc + 16'h0001 : 16'h0000;
			pc <= $changed(pump_oscillator_out_o) ? 5'h00 : pc + 5'h01;
			if ($changed(pump_oscillator_out_o))
				pst <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	sequence s_off_start;
		$rose(chop_off_a_o);
	endsequence
	sequence s_off_end;
		(bridge_en_a_i && en_i)[*5] ##0 $fell(chop_off_a_o);
	endsequence
	a_leg_no_short: assert property (!(g[3] && g[2]) && !(g[1] && g[0]))
		else $error("leg short in bridge A");
	a_dead_gap_hs: assert property ($rose(gate_hs1_a_o) |-> !$past(gate_ls1_a_o, 25))
		else $error("high side on without dead time");
	a_fast_off_all: assert property (s_off_start ##0 !$past(decay_sel_a_i, 4) |-> g == 4'h0)
		else $error("fast decay start not all off");
	a_slow_off_low: assert property (s_off_start ##0 ($past(decay_sel_a_i, 4)
		&& $past(phase_a_i, 4)) |-> g == 4'h8)
		else $error("slow decay start not low side off");
	a_min_on_hold: assert property (s_off_start |-> $past(lsx, 63))
		else $error("on time below minimum");
	a_off_len_exact: assert property (s_off_end ##0 offtime_timing_pin_a_i > 16'h0019
		|-> oc == offtime_timing_pin_a_i + 16'h0019)
		else $error("off interval length wrong");
	a_pump_half_per: assert property ($changed(pump_oscillator_out_o) && pst |-> pc == 5'h13)
		else $error("pump half period wrong");
	a_disable_all_off: assert property ((!bridge_en_a_i)[*4] |-> g == 4'h0 && !chop_off_a_o)
		else $error("disabled bridge still driven");
	a_fault_pull_en: assert property (fault_i[*4] |-> en_oe_o && !en_o)
		else $error("fault does not pull enable low");
endmodule // bpc_chopper_monitor
`default_nettype wire

// ### bench/bpc_winding_model.sv
/* Winding and sense comparator for one bridge.
   Assumes gate levels high = on; current is a plain up/down count. */
`timescale 1ns/1ps
`default_nettype none
module bpc_winding_model #(
	parameter [7:0] THR = 8'h50
) (
	input  wire logic clk_i,
	input  wire logic hs1_i,
	input  wire logic ls1_i,
	input  wire logic hs2_i,
	input  wire logic ls2_i,
	output logic      trip_o
);
	logic [7:0] amp = 8'h00;
	// Current builds while a diagonal conducts, else decays
	always @(posedge clk_i) begin
		if ((hs1_i && ls2_i) || (hs2_i && ls1_i))
			amp <= amp + 8'h01;
		else if (amp != 8'h00)
			amp <= amp - 8'h01;
	end
	// Comparator high while current exceeds reference
	assign trip_o = amp > THR;
endmodule // bpc_winding_model
`default_nettype wire

// ### bench/tb_bpc_chopper_top.sv
/* Bench for the two-bridge chopper; the bench is sequencer and enable driver.
   Assumes winding models on both bridges and one 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module tb_bpc_chopper_top;
	logic      clk_i = 1'b0;
	logic      srst_i = 1'b1;
	logic      en_drv = 1'b0;
	logic      fault_i = 1'b0;
	logic      be_a = 1'b0;
	logic      be_b = 1'b0;
	logic      dk_a = 1'b0;
	logic      dk_b = 1'b0;
	logic      hold_a = 1'b0;
	logic      ph_a = 1'b1;
	wire       trip_a, trip_b, en_o, en_oe_o, chop_a, chop_b, pump;
	wire [3:0] ga, gb;
	int        err_total = 0;
	int        num_checks = 0;
	int        cyc = 0;
	// Open-drain enable line, device pull-down wins
	wire       en_w = en_drv & ~en_oe_o;
	bpc_chopper_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .en_i(en_w), .en_o(en_o),
		.en_oe_o(en_oe_o), .fault_i(fault_i), .phase_a_i(ph_a), .bridge_en_a_i(be_a),
		.decay_sel_a_i(dk_a), .sense_trip_a_i(trip_a | hold_a),
		.offtime_timing_pin_a_i(16'h0040), .phase_b_i(1'b1), .bridge_en_b_i(be_b),
		.decay_sel_b_i(dk_b), .sense_trip_b_i(trip_b), .offtime_timing_pin_b_i(16'h0030),
		.gate_hs1_a_o(ga[3]), .gate_ls1_a_o(ga[2]), .gate_hs2_a_o(ga[1]), .gate_ls2_a_o(ga[0]),
		.gate_hs1_b_o(gb[3]), .gate_ls1_b_o(gb[2]), .gate_hs2_b_o(gb[1]), .gate_ls2_b_o(gb[0]),
		.chop_off_a_o(chop_a), .chop_off_b_o(chop_b), .pump_oscillator_out_o(pump));
	bpc_winding_model wm_a (.clk_i(clk_i), .hs1_i(ga[3]), .ls1_i(ga[2]), .hs2_i(ga[1]),
		.ls2_i(ga[0]), .trip_o(trip_a));
	bpc_winding_model wm_b (.clk_i(clk_i), .hs1_i(gb[3]), .ls1_i(gb[2]), .hs2_i(gb[1]),
		.ls2_i(gb[0]), .trip_o(trip_b));
	// Clock and hang guard
	initial forever #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			print_verdict;
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wait_off(input logic b, input logic v);
		int i;
		for (i = 0; i < 400 && (b ? chop_b : chop_a) !== v; i++)
			tick(1);
		chk("chop_off", v, b ? chop_b : chop_a);
	endtask
	task automatic t_reset;
		int n;
		logic p;
		chk("gates", 16'h0000, {ga, gb, chop_a, chop_b, en_oe_o});
		for (n = 0; n < 50 && pump === 1'b0; n++)
			tick(1);
		p = pump;
		for (n = 0; n < 50 && pump === p; n++)
			tick(1);
		chk("pump half period", 16'h0014, n);
		$display("done t_reset");
	endtask
	task automatic t_fast;
		int n;
		@(posedge clk_i) begin
			en_drv <= 1'b1;
			be_a <= 1'b1;
		end
		tick(20);
		chk("ga dead", 16'h0000, ga);
		tick(15);
		chk("ga on", 16'h0009, ga);
		wait_off(1'b0, 1'b1);
		chk("ga fast start", 16'h0000, ga);
		chk("gb idle", 16'h0000, {gb, chop_b});
		tick(30);
		chk("ga fast rec", 16'h0004, ga);
		for (n = 0; n < 200 && chop_a === 1'b1; n++)
			tick(1);
		chk("off length", 16'h0059, n + 30);
		chk("ga back on", 16'h0009, ga);
		$display("done t_fast");
	endtask
	task automatic t_slow;
		@(posedge clk_i) begin
			dk_a <= 1'b1;
			dk_b <= 1'b1;
			be_b <= 1'b1;
		end
		wait_off(1'b0, 1'b1);
		chk("ga slow start", 16'h0008, ga);
		tick(30);
		chk("ga slow rec", 16'h000a, ga);
		tick(39);
		chk("ga slow end", 16'h0008, ga);
		wait_off(1'b0, 1'b0);
		chk("ga low back", 16'h0009, ga);
		wait_off(1'b1, 1'b0);
		wait_off(1'b1, 1'b1);
		chk("gb slow start", 16'h0008, gb);
		$display("done t_slow");
	endtask
	task automatic t_blank;
		int n;
		@(posedge clk_i) be_a <= 1'b0;
		tick(100);
		@(posedge clk_i) be_a <= 1'b1;
		for (n = 0; n < 100 && ga !== 4'h9; n++)
			tick(1);
		// Short trip pulse early in the on-time must not end it
		@(posedge clk_i) hold_a <= 1'b1;
		tick(5);
		@(posedge clk_i) hold_a <= 1'b0;
		for (n = 0; n < 200 && chop_a !== 1'b1; n++)
			tick(1);
		chk("blank ignored", 16'h0001, n > 66);
		// Trip held through the next on-time: off at minimum on-time
		@(posedge clk_i) hold_a <= 1'b1;
		for (n = 0; n < 200 && ga !== 4'h9; n++)
			tick(1);
		for (n = 0; n < 100 && chop_a !== 1'b1; n++)
			tick(1);
		chk("on before off", 16'h0001, n > 62 && n < 67);
		@(posedge clk_i) hold_a <= 1'b0;
		$display("done t_blank");
	endtask
	task automatic t_enable;
		@(posedge clk_i) en_drv <= 1'b0;
		tick(5);
		chk("all off", 16'h0000, {ga, gb, chop_a, chop_b});
		@(posedge clk_i) en_drv <= 1'b1;
		tick(40);
		@(posedge clk_i) fault_i <= 1'b1;
		tick(5);
		chk("fault pull", 16'h0002, {en_oe_o, en_w});
		chk("fault off", 16'h0000, {ga, gb});
		@(posedge clk_i) fault_i <= 1'b0;
		tick(5);
		chk("pull gone", 16'h0001, {en_oe_o, en_w});
		tick(40);
		chk("resumed", 16'h0009, ga);
		$display("done t_enable");
	endtask
	task automatic t_phase;
		@(posedge clk_i) ph_a <= 1'b0;
		tick(5);
		chk("ga turn gap", 16'h0000, ga);
		tick(25);
		chk("ga phase low", 16'h0006, ga);
		$display("done t_phase");
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		tick(1);
		t_reset;
		t_fast;
		t_slow;
		t_blank;
		t_enable;
		t_phase;
		print_verdict;
	end
endmodule // tb_bpc_chopper_top
bind bpc_chopper_top bpc_chopper_monitor mon_u (.*);
`default_nettype wire
